// ===== design/dbau_pkg.sv
// constants, types and register map of the double-word bcd arithmetic unit
package dbau_pkg;
	// word indices on the apb bus, byte address is index times four
	localparam logic [5:0] IX_CTRL = 6'h00;
	localparam logic [5:0] IX_DST = 6'h01;
	localparam logic [5:0] IX_OPA = 6'h02;
	localparam logic [5:0] IX_OPB = 6'h03;
	localparam logic [5:0] IX_BIT = 6'h04;
	localparam logic [5:0] IX_FLAGS = 6'h05;
	localparam logic [5:0] IX_RES01 = 6'h06;
	localparam logic [5:0] IX_RES23 = 6'h07;
	localparam logic [5:0] IX_ISTAT = 6'h08;
	localparam logic [5:0] IX_IEN = 6'h09;
	localparam logic [5:0] IX_ICLR = 6'h0A;
	localparam logic [1:0] IX_COL_HI = 2'h1; // column bank at indices 0x10..0x1F
	// field positions
	localparam int CTRL_START = 8;
	localparam int DST_MEM = 15;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	// reset values
	localparam logic [15:0] DST_RST = 16'h0000;
	localparam logic [1:0] IEN_RST = 2'h0;
	// data memory area read-only window, word addresses
	localparam logic [14:0] MEM_RO_LO = 15'h03E8;
	localparam logic [14:0] MEM_RO_HI = 15'h07CF;
	// arithmetic limits
	localparam logic [27:0] DEC_LIM = 28'h5F5E100; // 10^8
	localparam logic [26:0] SEC_MAX = 27'h22550FF; // largest seconds count
	localparam logic [26:0] HOUR_S = 27'h0000E10;
	localparam logic [26:0] MIN_S = 27'h000003C;
	// operation codes
	typedef enum logic [3:0] {
		OP_ADD = 4'h0, OP_SUB = 4'h1, OP_MUL = 4'h2, OP_DIV = 4'h3,
		OP_TOBIN = 4'h4, OP_TOBCD = 4'h5, OP_CMP = 4'h6, OP_GATHER = 4'h7,
		OP_SCATTER = 4'h8, OP_HMS2SEC = 4'h9, OP_SEC2HMS = 4'hA
	} dbau_op_t;
	// condition flags
	typedef struct packed {
		logic err;
		logic eq;
		logic lt;
		logic gt;
		logic carry;
	} dbau_flags_t;
endpackage : dbau_pkg

// ===== design/dbau_core.sv
// double-word bcd arithmetic, conversion, compare and column transpose unit
//
// Notes on behaviour
// - bcd add of two 8-digit values plus carry
// - bcd subtract with carry, borrow sets carry
// - bcd multiply gives 16 digits in four words
// - divide: quotient in R,R+1, remainder R+2,R+3
// - 8-digit bcd converted to 32-bit binary
// - 32-bit binary converted to eight bcd digits
// - compare sets exactly one of gt/lt/eq
// - higher-address word is the high half
// - gather one bit column from 16 words
// - first word lands in destination bit 00
// - scatter source bits into a column, rest kept
// - hours/minutes/seconds converted to total seconds
// - seconds converted to h/m/s within maximum
// - read-only data memory words never written
`timescale 1ns/1ps
module dbau_core (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output dbau_pkg::dbau_flags_t flags
);
	// packed bcd digit test
	function automatic logic is_bcd(input logic [31:0] v);
		logic ok;
		ok = 1'b1;
		for (int d = 0; d < 8; d++) begin
			ok = ok & (v[4*d+:4] <= 4'h9);
		end
		return ok;
	endfunction : is_bcd
	// eight bcd digits to binary
	function automatic logic [26:0] bcd2bin(input logic [31:0] v);
		logic [26:0] r;
		r = 27'h0000000;
		for (int d = 7; d >= 0; d--) begin
			r = 27'(r * 27'h000000A + 27'(v[4*d+:4]));
		end
		return r;
	endfunction : bcd2bin
	// binary to sixteen bcd digits by shift and add three
	function automatic logic [63:0] bin2bcd(input logic [53:0] b);
		logic [63:0] r;
		r = 64'h0;
		for (int i = 53; i >= 0; i--) begin
			for (int d = 0; d < 16; d++) begin
				r[4*d+:4] = (r[4*d+:4] >= 4'h5) ? r[4*d+:4] + 4'h3 : r[4*d+:4];
			end
			r = {r[62:0], b[i]};
		end
		return r;
	endfunction : bin2bcd
	// registers seen by software
	dbau_pkg::dbau_op_t op_q, op_d;
	logic [15:0] dst_q, dst_d;
	logic [31:0] opa_q, opa_d, opb_q, opb_d;
	logic [3:0] bit_q, bit_d;
	dbau_pkg::dbau_flags_t flg_q, flg_d;
	logic [63:0] res_q, res_d;
	logic [1:0] ist_q, ist_d, ien_q, ien_d;
	logic [15:0][15:0] col_q, col_d;
	// decode and datapath nets
	logic [5:0] idx;
	logic [26:0] a, b, hs, mn, sc, hh, rm;
	logic [27:0] t;
	logic [53:0] prod;
	logic [63:0] r_n, q_bcd, m_bcd;
	logic [15:0][15:0] col_n;
	logic go_q, go_d, mapped, wr, cy_n, bad, ro, err_n;
	logic [4:0] nw;
	logic [14:0] span_hi;
	// apb decode, zero wait state answer
	assign idx = paddr[7:2];
	assign wr = psel & penable & pwrite;
	assign mapped = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0) &&
		((idx <= dbau_pkg::IX_ICLR) || (idx[5:4] == dbau_pkg::IX_COL_HI));
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign irq = |(ist_q & ien_q);
	assign flags = flg_q;
	// read data mux, unmapped and write-only words read zero
	always_comb begin
		prdata = 32'h0;
		if (psel && mapped) begin
			if (idx[5:4] == dbau_pkg::IX_COL_HI) begin
				prdata = {16'h0000, col_q[idx[3:0]]};
			end else begin
				case (idx)
					dbau_pkg::IX_CTRL: prdata = {27'h0, go_q, op_q};
					dbau_pkg::IX_DST: prdata = {16'h0000, dst_q};
					dbau_pkg::IX_OPA: prdata = opa_q;
					dbau_pkg::IX_OPB: prdata = opb_q;
					dbau_pkg::IX_BIT: prdata = {28'h0, bit_q};
					dbau_pkg::IX_FLAGS: prdata = {27'h0, flg_q};
					dbau_pkg::IX_RES01: prdata = res_q[31:0];
					dbau_pkg::IX_RES23: prdata = res_q[63:32];
					dbau_pkg::IX_ISTAT: prdata = {30'h0, ist_q};
					dbau_pkg::IX_IEN: prdata = {30'h0, ien_q};
					default: prdata = 32'h0;
				endcase
			end
		end
	end
	// operation datapath, results computed in the cycle after start
	always_comb begin
		a = bcd2bin(opa_q);
		b = bcd2bin(opb_q);
		hs = bcd2bin({16'h0000, opa_q[31:16]});
		mn = bcd2bin({24'h000000, opa_q[15:8]});
		sc = bcd2bin({24'h000000, opa_q[7:0]});
		hh = a / dbau_pkg::HOUR_S;
		rm = a % dbau_pkg::HOUR_S;
		t = 28'h0;
		prod = 54'(a) * 54'(b);
		q_bcd = 64'h0;
		m_bcd = 64'h0;
		r_n = res_q;
		col_n = col_q;
		cy_n = flg_q.carry;
		bad = 1'b0;
		nw = 5'h02;
		unique case (op_q)
			dbau_pkg::OP_ADD: begin
				bad = ~is_bcd(opa_q) | ~is_bcd(opb_q);
				t = 28'(a) + 28'(b) + 28'(flg_q.carry);
				cy_n = (t >= dbau_pkg::DEC_LIM);
				t = cy_n ? t - dbau_pkg::DEC_LIM : t;
				r_n[31:0] = 32'(bin2bcd(54'(t)));
			end
			dbau_pkg::OP_SUB: begin
				bad = ~is_bcd(opa_q) | ~is_bcd(opb_q);
				t = 28'(a) - 28'(b) - 28'(flg_q.carry);
				cy_n = t[27];
				t = cy_n ? t + dbau_pkg::DEC_LIM : t; // ten's complement on borrow
				r_n[31:0] = 32'(bin2bcd(54'(t)));
			end
			dbau_pkg::OP_MUL: begin
				bad = ~is_bcd(opa_q) | ~is_bcd(opb_q);
				r_n = bin2bcd(prod);
				nw = 5'h04;
			end
			dbau_pkg::OP_DIV: begin
				bad = ~is_bcd(opa_q) | ~is_bcd(opb_q) | (b == 27'h0000000);
				if (b != 27'h0000000) begin
					q_bcd = bin2bcd(54'(a / b));
					m_bcd = bin2bcd(54'(a % b));
				end
				r_n = {m_bcd[31:0], q_bcd[31:0]};
				nw = 5'h04;
			end
			dbau_pkg::OP_TOBIN: begin
				bad = ~is_bcd(opa_q);
				r_n[31:0] = 32'(a);
			end
			dbau_pkg::OP_TOBCD: begin
				bad = (opa_q >= 32'(dbau_pkg::DEC_LIM)); // more than eight digits
				r_n[31:0] = 32'(bin2bcd(54'(opa_q)));
			end
			dbau_pkg::OP_CMP: begin
				nw = 5'h00;
			end
			dbau_pkg::OP_GATHER: begin
				for (int i = 0; i < 16; i++) begin
					r_n[i] = col_q[i][bit_q];
				end
				nw = 5'h01;
			end
			dbau_pkg::OP_SCATTER: begin
				for (int i = 0; i < 16; i++) begin
					col_n[i][bit_q] = opa_q[i];
				end
				nw = 5'h10;
			end
			dbau_pkg::OP_HMS2SEC: begin
				bad = ~is_bcd(opa_q) | (mn >= dbau_pkg::MIN_S) | (sc >= dbau_pkg::MIN_S);
				t = 28'(hs * dbau_pkg::HOUR_S + mn * dbau_pkg::MIN_S + sc);
				r_n[31:0] = 32'(bin2bcd(54'(t)));
			end
			dbau_pkg::OP_SEC2HMS: begin
				bad = ~is_bcd(opa_q) | (a > dbau_pkg::SEC_MAX);
				q_bcd = bin2bcd(54'(rm / dbau_pkg::MIN_S));
				m_bcd = bin2bcd(54'(rm % dbau_pkg::MIN_S));
				r_n[15:0] = {q_bcd[7:0], m_bcd[7:0]};
				r_n[31:16] = 16'(bin2bcd(54'(hh)));
			end
			default: begin
				bad = 1'b1;
				nw = 5'h00;
			end
		endcase
		// result span must miss the read-only data memory words
		span_hi = dst_q[14:0] + 15'(nw) - 15'h0001;
		ro = dst_q[dbau_pkg::DST_MEM] && (nw != 5'h00) &&
			(span_hi >= dbau_pkg::MEM_RO_LO) && (dst_q[14:0] <= dbau_pkg::MEM_RO_HI);
		err_n = bad | ro;
	end
	// register writes, execution update and sticky events
	always_comb begin
		op_d = op_q;
		go_d = 1'b0;
		dst_d = dst_q;
		opa_d = opa_q;
		opb_d = opb_q;
		bit_d = bit_q;
		flg_d = flg_q;
		res_d = res_q;
		ien_d = ien_q;
		col_d = col_q;
		ist_d = ist_q;
		if (wr && mapped) begin
			if (idx[5:4] == dbau_pkg::IX_COL_HI) begin
				col_d[idx[3:0]] = pwdata[15:0];
			end else begin
				case (idx)
					dbau_pkg::IX_CTRL: begin
						op_d = dbau_pkg::dbau_op_t'(pwdata[3:0]);
						go_d = pwdata[dbau_pkg::CTRL_START];
					end
					dbau_pkg::IX_DST: dst_d = pwdata[15:0];
					dbau_pkg::IX_OPA: opa_d = pwdata;
					dbau_pkg::IX_OPB: opb_d = pwdata;
					dbau_pkg::IX_BIT: bit_d = pwdata[3:0];
					dbau_pkg::IX_FLAGS: flg_d.carry = pwdata[0];
					dbau_pkg::IX_IEN: ien_d = pwdata[1:0];
					dbau_pkg::IX_ICLR: ist_d = ist_q & ~pwdata[1:0];
					default: ;
				endcase
			end
		end
		// completion wins over a clear in the same cycle
		if (go_q) begin
			flg_d.err = err_n;
			ist_d[dbau_pkg::IRQ_DONE] = 1'b1;
			if (err_n) begin
				ist_d[dbau_pkg::IRQ_ERR] = 1'b1;
			end else begin
				res_d = r_n;
				col_d = col_n;
				flg_d.carry = cy_n;
				if (op_q == dbau_pkg::OP_CMP) begin
					flg_d.gt = (opa_q > opb_q);
					flg_d.lt = (opa_q < opb_q);
					flg_d.eq = (opa_q == opb_q);
				end
			end
		end
	end
	// state registers
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			op_q <= dbau_pkg::OP_ADD;
			go_q <= 1'b0;
			dst_q <= dbau_pkg::DST_RST;
			opa_q <= 32'h0;
			opb_q <= 32'h0;
			bit_q <= 4'h0;
			flg_q <= '0;
			res_q <= 64'h0;
			ien_q <= dbau_pkg::IEN_RST;
			ist_q <= 2'h0;
			col_q <= '0;
		end else begin
			op_q <= op_d;
			go_q <= go_d;
			dst_q <= dst_d;
			opa_q <= opa_d;
			opb_q <= opb_d;
			bit_q <= bit_d;
			flg_q <= flg_d;
			res_q <= res_d;
			ien_q <= ien_d;
			ist_q <= ist_d;
			col_q <= col_d;
		end
	end
	// helpers read only by the checks below
	logic col0_sel, opa_b0;
	assign col0_sel = col_q[0][bit_q];
	assign opa_b0 = opa_q[0];
	// checks on the datapath outcome
	property p_err_hold;
		@(posedge mclk) disable iff (!rstn) go_q && err_n |=> $stable(res_q) && flg_q.err;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error run changed results");
	property p_ro;
		@(posedge mclk) disable iff (!rstn) go_q && ro |=> flg_q.err && ist_q[1];
	endproperty
	a_ro: assert property (p_ro) else $error("read-only span not refused");
	property p_cmp_one;
		@(posedge mclk) disable iff (!rstn)
			go_q && op_q == dbau_pkg::OP_CMP |=> $onehot({flg_q.gt, flg_q.lt, flg_q.eq});
	endproperty
	a_cmp_one: assert property (p_cmp_one) else $error("compare flags not one-hot");
	property p_cmp_hi;
		@(posedge mclk) disable iff (!rstn)
			go_q && op_q == dbau_pkg::OP_CMP && opa_q[31:16] > opb_q[31:16] |=> flg_q.gt;
	endproperty
	a_cmp_hi: assert property (p_cmp_hi) else $error("high word not most significant");
	property p_sub_borrow;
		@(posedge mclk) disable iff (!rstn)
			go_q && op_q == dbau_pkg::OP_SUB && !err_n && opa_q < opb_q |=> flg_q.carry;
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow missed");
	property p_add_carry;
		@(posedge mclk) disable iff (!rstn) go_q && op_q == dbau_pkg::OP_ADD && !err_n &&
			opa_q == 32'h99999999 && opb_q != 32'h0 |=> flg_q.carry;
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry missed");
	property p_gather;
		@(posedge mclk) disable iff (!rstn)
			go_q && op_q == dbau_pkg::OP_GATHER && !err_n |=> res_q[0] == $past(col0_sel);
	endproperty
	a_gather: assert property (p_gather) else $error("gather bit 00 wrong");
	property p_scatter;
		@(posedge mclk) disable iff (!rstn)
			go_q && op_q == dbau_pkg::OP_SCATTER && !err_n |=> col0_sel == $past(opa_b0);
	endproperty
	a_scatter: assert property (p_scatter) else $error("scatter bit 00 wrong");
	property p_start;
		@(posedge mclk) disable iff (!rstn) wr && mapped && idx == dbau_pkg::IX_CTRL &&
			pwdata[dbau_pkg::CTRL_START] |=> go_q ##1 ist_q[0];
	endproperty
	a_start: assert property (p_start) else $error("start did not complete");
endmodule : dbau_core

// ===== sim/dbau_seq.sv
// sequencer model that issues apb transfers to the unit's register port
`timescale 1ns/1ps
module dbau_seq (
	input wire logic mclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	int tmo = 0;
	// bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// one transfer: setup, then access held until pready is seen at an edge, for at most 16 edges
	task automatic xfer(input logic w, input logic [5:0] ix, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {4'h0, ix, 2'h0};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) tmo++; // a stuck slave counts as a mismatch
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : dbau_seq

// ===== sim/tb.sv
// self-checking bench for the double-word bcd arithmetic unit
`timescale 1ns/1ps
module tb;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	dbau_pkg::dbau_flags_t flags;
	int fails = 0;
	int checks = 0;
	// 20 mhz clock
	always #25 mclk = ~mclk;
	dbau_core i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .flags(flags));
	dbau_seq i_seq (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	// compare and count
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			$display("wrong value %s expected %h seen %h", s, x, g);
			fails++;
		end
	endtask : chk
	// one transfer; a slave that never answers ends the run as a failure
	task automatic bus(input logic w, input logic [5:0] ix, input logic [31:0] d);
		i_seq.xfer(w, ix, d, q, e);
		if (i_seq.tmo != 0) begin
			wrap_up;
		end
	endtask : bus
	task automatic wr(input logic [5:0] ix, input logic [31:0] d);
		bus(1'b1, ix, d);
	endtask : wr
	task automatic rc(input logic [5:0] ix, input logic [31:0] x, input string s);
		bus(1'b0, ix, 32'h00000000);
		chk(s, x, q);
	endtask : rc
	// load operands, start the op, compare both result pairs and the flags
	task automatic t(input logic [3:0] op, input logic [31:0] a, b, r01, r23,
		input logic [4:0] f);
		wr(dbau_pkg::IX_OPA, a);
		wr(dbau_pkg::IX_OPB, b);
		wr(dbau_pkg::IX_CTRL, {23'h000000, 1'b1, 4'h0, op});
		rc(dbau_pkg::IX_RES01, r01, "res01");
		rc(dbau_pkg::IX_RES23, r23, "res23");
		rc(dbau_pkg::IX_FLAGS, {27'h0000000, f}, "flags");
	endtask : t
	task automatic wrap_up;
		fails += i_seq.tmo;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	// watchdog on the whole run
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		wrap_up;
	end
	// main sequence
	initial begin
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		rc(dbau_pkg::IX_DST, {16'h0000, dbau_pkg::DST_RST}, "dst");
		rc(dbau_pkg::IX_IEN, {30'h00000000, dbau_pkg::IEN_RST}, "ien");
		rc(dbau_pkg::IX_ISTAT, 32'h00000000, "istat");
		rc(dbau_pkg::IX_FLAGS, 32'h00000000, "flags");
		chk("pready", 32'h1, {31'h0, pready});
		$display("test reset done");
		wr(dbau_pkg::IX_FLAGS, 32'h00000001);
		wr(dbau_pkg::IX_IEN, 32'h00000003);
		t(4'h0, 32'h99999999, 32'h00000001, 32'h00000001, 32'h0, 5'h01);
		t(4'h1, 32'h00000005, 32'h00000010, 32'h99999994, 32'h0, 5'h01);
		t(4'h1, 32'h00000020, 32'h00000005, 32'h00000014, 32'h0, 5'h00);
		t(4'h0, 32'h12345678, 32'h87654321, 32'h99999999, 32'h0, 5'h00);
		t(4'h2, 32'h99999999, 32'h99999999, 32'h00000001, 32'h99999998, 5'h00);
		t(4'h3, 32'h00000100, 32'h00000007, 32'h00000014, 32'h2, 5'h00);
		t(4'h4, 32'h99999999, 32'h0, 32'h05F5E0FF, 32'h2, 5'h00);
		t(4'h5, 32'h05F5E0FF, 32'h0, 32'h99999999, 32'h2, 5'h00);
		t(4'h9, 32'h00023015, 32'h0, 32'h00009015, 32'h2, 5'h00);
		t(4'hA, 32'h35999999, 32'h0, 32'h99995959, 32'h2, 5'h00);
		chk("irq", 32'h1, {31'h0, irq});
		$display("test arithmetic done");
		t(4'h0, 32'h0000000A, 32'h0, 32'h99995959, 32'h2, 5'h10);
		t(4'h3, 32'h00000001, 32'h0, 32'h99995959, 32'h2, 5'h10);
		t(4'h5, 32'h05F5E100, 32'h0, 32'h99995959, 32'h2, 5'h10);
		t(4'h9, 32'h00000060, 32'h0, 32'h99995959, 32'h2, 5'h10);
		t(4'hA, 32'h36000000, 32'h0, 32'h99995959, 32'h2, 5'h10);
		t(4'hB, 32'h0, 32'h0, 32'h99995959, 32'h2, 5'h10);
		chk("err_out", 32'h1, {31'h0, flags.err});
		rc(dbau_pkg::IX_ISTAT, 32'h00000003, "istat");
		wr(dbau_pkg::IX_ICLR, 32'h00000003);
		rc(dbau_pkg::IX_ISTAT, 32'h00000000, "istat");
		rc(dbau_pkg::IX_ICLR, 32'h00000000, "iclr");
		chk("irq", 32'h0, {31'h0, irq});
		$display("test errors done");
		wr(dbau_pkg::IX_IEN, 32'h00000002);
		t(4'h6, 32'h00010000, 32'h0000FFFF, 32'h99995959, 32'h2, 5'h02);
		t(4'h6, 32'h0000FFFF, 32'h00010000, 32'h99995959, 32'h2, 5'h04);
		t(4'h6, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h99995959, 32'h2, 5'h08);
		chk("irq", 32'h0, {31'h0, irq});
		wr(dbau_pkg::IX_DST, 32'h000083E6);
		t(4'h0, 32'h00000001, 32'h00000001, 32'h00000002, 32'h2, 5'h08);
		wr(dbau_pkg::IX_DST, 32'h000083E7);
		t(4'h0, 32'h00000001, 32'h00000001, 32'h00000002, 32'h2, 5'h18);
		chk("irq", 32'h1, {31'h0, irq});
		$display("test compare done");
		for (int i = 0; i < 16; i++)
			wr({dbau_pkg::IX_COL_HI, 4'(i)}, i[0] ? 32'h1238 : 32'h1230);
		wr(dbau_pkg::IX_BIT, 32'h00000003);
		wr(dbau_pkg::IX_DST, 32'h00000000);
		wr(dbau_pkg::IX_CTRL, 32'h00000107);
		bus(1'b0, dbau_pkg::IX_RES01, 32'h0);
		chk("gather", 32'h0000AAAA, {16'h0000, q[15:0]});
		wr(dbau_pkg::IX_OPA, 32'h000000F0);
		wr(dbau_pkg::IX_CTRL, 32'h00000108);
		for (int i = 0; i < 16; i++)
			rc({dbau_pkg::IX_COL_HI, 4'(i)}, (i > 3 && i < 8) ? 32'h1238 : 32'h1230, "col");
		bus(1'b0, 6'h0B, 32'h0);
		chk("slverr", 32'h1, {31'h0, e});
		$display("test columns done");
		wrap_up;
	end
endmodule : tb
